/* bbse_addr.sv */
// Data address former: access bank, banked page or indexed mode.
`timescale 1ns/1ps
module bbse_addr
    import bbse_pkg::*;
(
    // Operand fields
    input wire logic [7:0] file_addr,
    input wire logic acc_sel,
    // Core state
    input wire logic [3:0] bank_select_register,
    input wire logic ext_set_en,
    // Result
    output bbse_pkg::bbse_daddr_s daddr
);
    import bbse_pkg::*;

    // ----------------------------------------------------------------
    // Address selection
    // ----------------------------------------------------------------

    // The indexed case only flags the request; the offset arithmetic
    // belongs to the indexed unit outside this block.
    always_comb begin
        daddr = '0;
        if (acc_sel) begin
            daddr.addr = {bank_select_register, file_addr};
        end else if (ext_set_en && file_addr <= ILO_LIMIT) begin
            daddr.addr = {ACCESS_LO_PAGE, file_addr};
            daddr.indexed = 1'b1;
        end else if (file_addr < ACCESS_SPLIT) begin
            daddr.addr = {ACCESS_LO_PAGE, file_addr};
        end else begin
            daddr.addr = {ACCESS_HI_PAGE, file_addr};
        end
    end

endmodule

/* bbse_core.sv */
// Branch and bit-set decode and execute for the 8-bit core.
`timescale 1ns/1ps
// What this block does
// - Opcode E6 branches when negative flag is one.
// - Opcode E3 branches when carry flag is zero.
// - Opcode E7 branches when negative flag is zero.
// - Opcode E5 branches when overflow flag is zero.
// - Opcode E1 branches when zero flag is zero.
// - Taken target is address plus two plus twice offset; flags kept.
// - Conditional offset is signed low byte, doubled.
// - Conditional branch is one word, one cycle untaken, two taken.
// - Upper bits 11010 is the jump with signed eleven-bit offset.
// - Jump always takes two cycles, second one a no-operation.
// - Bit set reads byte, forces chosen bit, writes back, flags untouched.
// - Access bit zero addresses the fixed access bank.
// - Access bit one uses the bank select register page.
// - Extended set with access bit zero and address up to 5Fh is indexed.
module bbse_core
    import bbse_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Program memory
    output logic [bbse_pkg::PC_W-1:0] pm_addr_q,
    input wire logic [bbse_pkg::IR_W-1:0] pm_data,
    // Core state from elsewhere
    input wire bbse_pkg::bbse_flags_s alu_flags,
    input wire logic [3:0] bank_select_register,
    input wire logic ext_set_en,
    // Data memory
    output logic [bbse_pkg::DA_W-1:0] dm_addr_q,
    output logic dm_rd_en_q,
    input wire logic [7:0] dm_rdata,
    output logic dm_wr_en_q,
    output logic [7:0] dm_wdata_q,
    output logic dm_indexed_q,
    // Status
    output logic [1:0] phase_q,
    output logic flush_cycle_q,
    output logic flags_wr_q
);
    import bbse_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    bbse_phase_e ph_q;
    bbse_kind_e kind_q;
    logic [PC_W-1:0] pc_q;
    logic [IR_W-1:0] ir_q;
    logic flush_q;
    logic take_q;
    logic [PC_W-1:0] ofs_q;
    logic [7:0] data_q;
    logic [7:0] bit_mask;
    logic [7:0] rel8;
    logic [10:0] rel11;
    logic [7:0] upper;
    logic cond_hit;
    bbse_daddr_s daddr;

    assign upper = ir_q[15:8];
    assign rel8 = ir_q[REL8_MSB:0];
    assign rel11 = ir_q[REL11_MSB:0];

    // ----------------------------------------------------------------
    // Address former
    // ----------------------------------------------------------------
    bbse_addr u_addr (
        .file_addr(ir_q[7:0]),
        .acc_sel(ir_q[ACC_BIT]),
        .bank_select_register(bank_select_register),
        .ext_set_en(ext_set_en),
        .daddr(daddr)
    );

    // ----------------------------------------------------------------
    // Condition evaluation
    // ----------------------------------------------------------------

    // Flags are sampled at Q1, so the arithmetic result of the previous
    // instruction must be settled by then.
    always_comb begin
        cond_hit = 1'b0;
        case (upper)
            OP_ON_NEG: cond_hit = alu_flags.neg;
            OP_ON_NC: cond_hit = !alu_flags.carry;
            OP_ON_NN: cond_hit = !alu_flags.neg;
            OP_ON_NOV: cond_hit = !alu_flags.ovf;
            OP_ON_NZ: cond_hit = !alu_flags.zero;
            default: cond_hit = 1'b0;
        endcase
    end

    // One-hot mask for the selected bit.
    always_comb begin
        bit_mask = 8'h01 << ir_q[BSEL_MSB:BSEL_LSB];
    end

    // ----------------------------------------------------------------
    // Phase sequencer
    // ----------------------------------------------------------------

    // Free-running four-phase counter; every instruction cycle is four
    // clocks, so a slow branch costs eight.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ph_q <= PH_Q1;
        end else begin
            case (ph_q)
                PH_Q1: ph_q <= PH_Q2;
                PH_Q2: ph_q <= PH_Q3;
                PH_Q3: ph_q <= PH_Q4;
                PH_Q4: ph_q <= PH_Q1;
                default: ph_q <= PH_Q1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Decode at Q1
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            kind_q <= K_NOP;
            take_q <= 1'b0;
            ofs_q <= '0;
        end else if (ph_q == PH_Q1) begin
            take_q <= 1'b0;
            ofs_q <= '0;
            if (flush_q) begin
                kind_q <= K_NOP;
            end else if (upper[7:4] == 4'hE && cond_hit) begin
                kind_q <= K_COND;
                take_q <= 1'b1;
                ofs_q <= {{12{rel8[7]}}, rel8, 1'b0};
            end else if (upper[7:4] == 4'hE) begin
                kind_q <= K_COND;
            end else if (upper[7:3] == OP_JUMP5) begin
                kind_q <= K_JUMP;
                take_q <= 1'b1;
                ofs_q <= {{9{rel11[10]}}, rel11, 1'b0};
            end else if (upper[7:4] == OP_BSET4) begin
                kind_q <= K_BSET;
            end else begin
                kind_q <= K_NOP;
            end
        end
    end

    // ----------------------------------------------------------------
    // Fetch and program counter at Q4
    // ----------------------------------------------------------------

    // pc_q already points past the branch when it executes, so adding
    // the doubled offset gives branch address plus two plus 2n.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pc_q <= PC_RESET;
            ir_q <= IR_RESET;
        end else if (ph_q == PH_Q4) begin
            ir_q <= pm_data;
            if (take_q) begin
                pc_q <= pc_q + ofs_q;
            end else begin
                pc_q <= pc_q + PC_STEP;
            end
        end
    end

    // A taken branch turns the word fetched behind it into a bubble.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flush_q <= 1'b0;
        end else if (ph_q == PH_Q4) begin
            flush_q <= take_q;
        end
    end

    // ----------------------------------------------------------------
    // Data memory read-modify-write
    // ----------------------------------------------------------------

    // Read strobe in Q2, data captured in Q3, write strobe in Q4; the
    // whole byte goes back, so other bits keep their read values.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dm_addr_q <= '0;
            dm_rd_en_q <= 1'b0;
            dm_wr_en_q <= 1'b0;
            dm_wdata_q <= 8'h00;
            dm_indexed_q <= 1'b0;
            data_q <= 8'h00;
        end else begin
            dm_rd_en_q <= 1'b0;
            dm_wr_en_q <= 1'b0;
            if (ph_q == PH_Q1 && !flush_q && upper[7:4] == OP_BSET4) begin
                dm_addr_q <= daddr.addr;
                dm_indexed_q <= daddr.indexed;
                dm_rd_en_q <= 1'b1;
            end
            if (ph_q == PH_Q2 && kind_q == K_BSET) begin
                data_q <= dm_rdata;
            end
            if (ph_q == PH_Q3 && kind_q == K_BSET) begin
                dm_wdata_q <= data_q | bit_mask;
                dm_wr_en_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------

    // None of these instructions writes the status flags.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_wr_q <= 1'b0;
        end else begin
            flags_wr_q <= 1'b0;
        end
    end

    assign pm_addr_q = pc_q;
    assign phase_q = ph_q;
    assign flush_cycle_q = flush_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_neg_taken: assert property (
        (ph_q == PH_Q1 && !flush_q && upper == OP_ON_NEG) |=>
            (take_q == $past(alu_flags.neg)))
        else $error("negative branch decision wrong");

    a_nc_taken: assert property (
        (ph_q == PH_Q1 && !flush_q && upper == OP_ON_NC) |=>
            (take_q == !$past(alu_flags.carry)))
        else $error("carry clear branch decision wrong");

    a_nn_taken: assert property (
        (ph_q == PH_Q1 && !flush_q && upper == OP_ON_NN) |=>
            (take_q == !$past(alu_flags.neg)))
        else $error("non-negative branch decision wrong");

    a_nov_taken: assert property (
        (ph_q == PH_Q1 && !flush_q && upper == OP_ON_NOV) |=>
            (take_q == !$past(alu_flags.ovf)))
        else $error("no overflow branch decision wrong");

    a_nz_taken: assert property (
        (ph_q == PH_Q1 && !flush_q && upper == OP_ON_NZ) |=>
            (take_q == !$past(alu_flags.zero)))
        else $error("non-zero branch decision wrong");

    a_rel8_target: assert property (
        (ph_q == PH_Q1 && !flush_q && upper == OP_ON_NEG
            && alu_flags.neg) |-> ##4
            (pc_q == $past(pc_q, 4)
                + {{12{$past(rel8[7], 4)}}, $past(rel8, 4), 1'b0}))
        else $error("short branch target wrong");

    a_jump_target: assert property (
        (ph_q == PH_Q1 && !flush_q && upper[7:3] == OP_JUMP5) |-> ##4
            (pc_q == $past(pc_q, 4)
                + {{9{$past(rel11[10], 4)}}, $past(rel11, 4), 1'b0}))
        else $error("jump target wrong");

    a_untaken_step: assert property (
        (ph_q == PH_Q4 && !take_q) |=> (pc_q == $past(pc_q) + PC_STEP))
        else $error("untaken step wrong");

    a_flush_bubble: assert property (
        (ph_q == PH_Q4 && take_q) |=>
            (flush_q && !dm_rd_en_q) [*4] ##1 (kind_q == K_NOP))
        else $error("taken branch did not insert bubble");

    a_jump_always: assert property (
        (ph_q == PH_Q1 && !flush_q && upper[7:3] == OP_JUMP5) |=> take_q)
        else $error("jump not taken");

    a_bset_write: assert property (
        (ph_q == PH_Q3 && kind_q == K_BSET) |=>
            (dm_wr_en_q && dm_wdata_q == ($past(data_q) | $past(bit_mask))))
        else $error("bit set write-back wrong");

    // Checked on every cycle that executes one of these instructions,
    // so a stray flag write in any phase is caught.
    a_no_flag_wr: assert property (
        (kind_q != K_NOP) |-> !flags_wr_q)
        else $error("flags written by branch");

    a_bank_page: assert property (
        (dm_rd_en_q && $past(ir_q[ACC_BIT])) |->
            (dm_addr_q[11:8] == $past(bank_select_register)))
        else $error("banked page not used");

    a_access_bank: assert property (
        (dm_rd_en_q && !$past(ir_q[ACC_BIT]) && !dm_indexed_q) |->
            (dm_addr_q[11:8] == (($past(ir_q[7:0]) < ACCESS_SPLIT)
                ? ACCESS_LO_PAGE : ACCESS_HI_PAGE)))
        else $error("access bank address wrong");

    a_indexed_flag: assert property (
        dm_rd_en_q |-> (dm_indexed_q == (!$past(ir_q[ACC_BIT])
            && $past(ext_set_en) && $past(ir_q[7:0]) <= ILO_LIMIT)))
        else $error("indexed mode flag wrong");

    c_cond_taken: cover property (
        ph_q == PH_Q4 && take_q && kind_q == K_COND);
    c_cond_untaken: cover property (
        ph_q == PH_Q4 && !take_q && kind_q == K_COND);
    c_jump: cover property (ph_q == PH_Q4 && kind_q == K_JUMP);
    c_bset: cover property (dm_wr_en_q && dm_indexed_q == 1'b0);

endmodule

/* bbse_pkg.sv */
// Shared constants and types for the branch and bit-set execute block.
package bbse_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int PC_W = 21;
    localparam int IR_W = 16;
    localparam int DA_W = 12;

    // ----------------------------------------------------------------
    // Opcode patterns (upper instruction bits)
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_ON_NEG = 8'hE6;
    localparam logic [7:0] OP_ON_NC = 8'hE3;
    localparam logic [7:0] OP_ON_NN = 8'hE7;
    localparam logic [7:0] OP_ON_NOV = 8'hE5;
    localparam logic [7:0] OP_ON_NZ = 8'hE1;
    localparam logic [4:0] OP_JUMP5 = 5'h1A;
    localparam logic [3:0] OP_BSET4 = 4'h8;

    // ----------------------------------------------------------------
    // Instruction field positions
    // ----------------------------------------------------------------
    localparam int ACC_BIT = 8;
    localparam int BSEL_LSB = 9;
    localparam int BSEL_MSB = 11;
    localparam int REL8_MSB = 7;
    localparam int REL11_MSB = 10;

    // ----------------------------------------------------------------
    // Reset values and address constants
    // ----------------------------------------------------------------
    localparam logic [20:0] PC_RESET = 21'h0_0000;
    localparam logic [20:0] PC_STEP = 21'h0_0002;
    localparam logic [15:0] IR_RESET = 16'h0000;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] ILO_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_HI_PAGE = 4'hF;
    localparam logic [3:0] ACCESS_LO_PAGE = 4'h0;
    localparam logic [3:0] BANK_RESET = 4'h0;

    // ----------------------------------------------------------------
    // Timing: one instruction cycle is four phases of sys_clk
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PHASES_PER_CYCLE = 4;
    localparam int INSTR_CYCLE_NS = CLK_PERIOD_NS * PHASES_PER_CYCLE;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bbse_phase_e;
    typedef enum logic [1:0] {K_NOP, K_COND, K_JUMP, K_BSET} bbse_kind_e;

    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
        logic carry;
    } bbse_flags_s;

    typedef struct packed {
        logic [11:0] addr;
        logic indexed;
    } bbse_daddr_s;

endpackage

/* test_branch_and_bit_set_exec.sv */
// Self-checking testbench for the branch and bit-set execute block.
`timescale 1ns/1ps
module test_branch_and_bit_set_exec;
    import bbse_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [PC_W-1:0] pm_addr_q;
    logic [IR_W-1:0] pm_data;
    bbse_flags_s alu_flags = '0;
    logic [3:0] bank_select_register = 4'h0;
    logic ext_set_en = 1'b0;
    logic [DA_W-1:0] dm_addr_q;
    logic dm_rd_en_q;
    logic [7:0] dm_rdata;
    logic dm_wr_en_q;
    logic [7:0] dm_wdata_q;
    logic dm_indexed_q;
    logic [1:0] phase_q;
    logic flush_cycle_q;
    logic flags_wr_q;
    logic [15:0] prog [0:255];
    int miscompares = 0;
    int compares = 0;
    int rd_cnt = 0;
    int wr_cnt = 0;
    int flush_cnt = 0;
    int flag_cnt = 0;
    logic [11:0] rd_addr;
    logic [11:0] wr_addr;
    logic rd_idx;
    logic [1:0] rd_ph;
    logic [1:0] wr_ph;
    logic [7:0] wr_data;

    // Free-running core clock, 10 ns period.
    always #5 sys_clk = ~sys_clk;

    // Program words outside the first 256 read as no-ops, so far targets
    // land on harmless code.
    assign pm_data = (pm_addr_q[20:9] == 12'h000) ? prog[pm_addr_q[8:1]] :
                     16'h0000;
    // Data bytes follow a fixed pattern so the expected write is computable.
    assign dm_rdata = dm_addr_q[7:0] ^ 8'hA5;

    bbse_core dut (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pm_addr_q(pm_addr_q),
        .pm_data(pm_data),
        .alu_flags(alu_flags),
        .bank_select_register(bank_select_register),
        .ext_set_en(ext_set_en),
        .dm_addr_q(dm_addr_q),
        .dm_rd_en_q(dm_rd_en_q),
        .dm_rdata(dm_rdata),
        .dm_wr_en_q(dm_wr_en_q),
        .dm_wdata_q(dm_wdata_q),
        .dm_indexed_q(dm_indexed_q),
        .phase_q(phase_q),
        .flush_cycle_q(flush_cycle_q),
        .flags_wr_q(flags_wr_q)
    );

    // Output monitor samples at the falling edge, where outputs are settled.
    always @(negedge sys_clk) begin
        if (dm_rd_en_q === 1'b1) begin
            rd_cnt++;
            rd_addr = dm_addr_q;
            rd_idx = dm_indexed_q;
            rd_ph = phase_q;
        end
        if (dm_wr_en_q === 1'b1) begin
            wr_cnt++;
            wr_addr = dm_addr_q;
            wr_data = dm_wdata_q;
            wr_ph = phase_q;
        end
        if (flush_cycle_q === 1'b1) flush_cnt++;
        if (flags_wr_q !== 1'b0) flag_cnt++;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("Counts: %0d compares, %0d miscompares", compares,
                 miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    // Reset, run word w0 at address 0 with w1 behind it, then judge the
    // program counter over two instruction cycles and the side effects.
    task automatic run_one(input logic [15:0] w0, input logic [15:0] w1,
                           input logic [3:0] fl, input logic tk,
                           input logic [20:0] tgt, input int exp_wr,
                           input string what);
        for (int i = 0; i < 256; i++) prog[i] = 16'h0000;
        prog[0] = w0;
        prog[1] = w1;
        alu_flags = fl;
        reset_n = 1'b0;
        repeat (12) @(negedge sys_clk);
        check(pm_addr_q === PC_RESET && phase_q === 2'h0, {what, " reset"});
        rd_cnt = 0;
        wr_cnt = 0;
        flush_cnt = 0;
        flag_cnt = 0;
        reset_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        check(pm_addr_q === (tk ? tgt : 21'h0_0004), {what, " pc"});
        repeat (4) @(negedge sys_clk);
        check(pm_addr_q === (tk ? tgt + PC_STEP : 21'h0_0006),
              {what, " next pc"});
        check(flush_cnt === (tk ? 4 : 0), {what, " bubble"});
        check(wr_cnt === exp_wr, {what, " writes"});
        check(flag_cnt === 0, {what, " flag write"});
    endtask

    // A taken case and an untaken case, each with a bit set behind it:
    // the bit set must be discarded when taken and executed when not.
    task automatic cond(input logic [7:0] op, input logic [7:0] n,
                        input logic [3:0] ft, input logic [3:0] fn,
                        input string what);
        logic [20:0] tgt;
        tgt = 21'h0_0002 + {{12{n[7]}}, n, 1'b0};
        run_one({op, n}, 16'h8420, ft, 1'b1, tgt, 0, what);
        run_one({op, n}, 16'h8420, fn, 1'b0, tgt, 1, what);
        $display("test %s done", what);
    endtask

    task automatic jump(input logic [10:0] n, input logic [3:0] fl);
        logic [20:0] tgt;
        tgt = 21'h0_0002 + {{9{n[10]}}, n, 1'b0};
        run_one({OP_JUMP5, n}, 16'h8420, fl, 1'b1, tgt, 0, "jump");
    endtask

    // Bit set of bit b at file f; ea and ei are the expected address and
    // indexed marker.
    task automatic bset(input logic [2:0] b, input logic a,
                        input logic [7:0] f, input logic [3:0] bank,
                        input logic ext, input logic [11:0] ea,
                        input logic ei);
        logic [7:0] d;
        bank_select_register = bank;
        ext_set_en = ext;
        d = (ea[7:0] ^ 8'hA5) | (8'h01 << b);
        run_one({OP_BSET4, b, a, f}, 16'h0000, 4'h0, 1'b0, 21'h0_0000, 1,
                "bit set");
        check(rd_cnt === 1 && rd_ph === 2'h1 && rd_addr === ea &&
              rd_idx === ei, "bit set read");
        check(wr_ph === 2'h3 && wr_addr === ea && wr_data === d,
              "bit set write");
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_conditional();
        // Flags are {neg, ovf, zero, carry}; the others sit at levels that
        // would flip a branch testing the wrong flag.
        cond(OP_ON_NEG, 8'h7F, 4'hF, 4'h7, "negative");
        cond(OP_ON_NC, 8'h80, 4'hE, 4'h1, "carry clear");
        cond(OP_ON_NN, 8'h01, 4'h7, 4'h8, "nonnegative");
        cond(OP_ON_NOV, 8'hFF, 4'hB, 4'h4, "no overflow");
        cond(OP_ON_NZ, 8'h40, 4'hD, 4'h2, "nonzero");
    endtask

    task automatic t_jump();
        // Both ends of the offset range and an offset of one, with flags all clear, all set and negative only.
        jump(11'h3FF, 4'h0);
        jump(11'h400, 4'hF);
        jump(11'h001, 4'h8);
        $display("test jump done");
    endtask

    task automatic t_bit_set();
        bset(3'h0, 1'b1, 8'h3C, 4'h7, 1'b0, 12'h73C, 1'b0);
        bset(3'h1, 1'b0, 8'h3C, 4'h7, 1'b0, 12'h03C, 1'b0);
        bset(3'h2, 1'b0, 8'h80, 4'h7, 1'b0, 12'hF80, 1'b0);
        bset(3'h3, 1'b0, 8'h5F, 4'h7, 1'b1, 12'h05F, 1'b1);
        bset(3'h4, 1'b0, 8'h60, 4'h7, 1'b1, 12'hF60, 1'b0);
        bset(3'h5, 1'b1, 8'h10, 4'h2, 1'b1, 12'h210, 1'b0);
        bset(3'h6, 1'b0, 8'h5F, 4'h2, 1'b0, 12'h05F, 1'b0);
        bset(3'h7, 1'b1, 8'hFF, 4'hF, 1'b0, 12'hFFF, 1'b0);
        $display("test bit set done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 256; i++) prog[i] = 16'h0000;
        @(negedge sys_clk);
        t_conditional();
        t_jump();
        t_bit_set();
        end_of_test();
    end

    // A hang is cut short well past the roughly 500 cycles the run needs.
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end

endmodule
